// ---- logic/backlight_misc_consts.vh ----
`ifndef BACKLIGHT_MISC_CONSTS_VH
`define BACKLIGHT_MISC_CONSTS_VH
`define ADDR_SOFT_RESTART 8'h0F
`define ADDR_DUTY_LOW 8'h12
`define ADDR_DUTY_HIGH 8'h13
`define ADDR_SILICON_STEP 8'h1F
`define ADDR_FILTER_LEVEL 8'h50
`define ADDR_CURRENT_A 8'h05
`define ADDR_CURRENT_B 8'h06
`define ADDR_BRIGHT_A 8'h03
`define ADDR_BRIGHT_B 8'h04
`define ADDR_TRACK_CTRL 8'h00
`define SOFT_RESTART_BIT 0
`define DUTY_HIGH_BIT 0
`define TRACK_BIT 0
`define FILTER_RESET 2'h0
`define DUTY_RESET 9'h000
`define DUTY_FULL 9'h100
`define CURRENT_RESET 5'h00
`define BRIGHT_RESET 8'h00
`define SILICON_STEP_DEFAULT 8'h5A
`endif

// ---- logic/duty_measure.v ----
`timescale 1ns/1ns
`include "backlight_misc_consts.vh"
module duty_measure #(
	parameter WINDOW = 256
) (
	input wire clock,
	input wire resetn,
	input wire softClear,
	input wire pwmSync,
	output reg [8:0] duty_q
);
	// Sized copy so the compare below takes a plain part-select
	localparam [31:0] LAST_COUNT = WINDOW - 1;
	reg [8:0] cnt_q;
	reg [8:0] high_q;
	wire last = (cnt_q == LAST_COUNT[8:0]);
	wire [8:0] highNext = high_q + {8'h00, pwmSync};
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 9'h000;
			high_q <= 9'h000;
			duty_q <= `DUTY_RESET;
		end else if (softClear) begin
			cnt_q <= 9'h000;
			high_q <= 9'h000;
			duty_q <= `DUTY_RESET;
		end else if (last) begin
			cnt_q <= 9'h000;
			high_q <= 9'h000;
			// Counts over 256 samples, so the value tops out at 9'h100
			duty_q <= (highNext >= `DUTY_FULL) ? `DUTY_FULL : highNext;
		end else begin
			cnt_q <= cnt_q + 9'h001;
			high_q <= highNext;
		end
	end
endmodule // duty_measure

// ---- logic/backlight_misc_registers.v ----
// Functional notes
// - Writing one to 0x0F bit0 resets registers
// - Nine-bit duty: low at 0x12, bit8 0x13
// - Duty never above 256, full is 100h
// - Low bits nonzero means bit8 zero
// - Filter level bits 1:0 at 0x50, reset zero
// - Revision byte at 0x1F always readable
// - Five-bit full-scale code per bank
// - Eight-bit brightness scales within full scale
// - Separate settings for each sink
// - Tracking drives both sinks from one brightness
// - Current limit holds switch off rest of period
`timescale 1ns/1ns
`include "backlight_misc_consts.vh"
module backlight_misc_registers #(
	parameter [7:0] SILICON_STEP = `SILICON_STEP_DEFAULT,
	parameter PERIOD_CYCLES = 100
) (
	input wire clock,
	input wire resetn,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	input wire pwmIn,
	input wire currentLimit,
	output reg powerSwitch,
	output reg [4:0] fullScaleA,
	output reg [4:0] fullScaleB,
	output reg [7:0] sinkLevelA,
	output reg [7:0] sinkLevelB,
	output reg [1:0] inputFilterLevel
);
	// SILICON_STEP default is arbitrary
	reg pwmMeta_q, pwmSync_q, limMeta_q, limSync_q;
	reg softClear_q;
	reg [1:0] filter_q;
	reg [4:0] curA_q, curB_q;
	reg [7:0] brA_q, brB_q;
	reg track_q;
	reg [7:0] per_q;
	reg limHold_q;
	reg [7:0] rdata_d;
	wire [8:0] duty;
	wire wrRestart = regWrite && regAddr == `ADDR_SOFT_RESTART && regWdata[`SOFT_RESTART_BIT];
	localparam [31:0] PERIOD_LAST = PERIOD_CYCLES - 1;
	wire periodEnd = (per_q == PERIOD_LAST[7:0]);

	duty_measure #(.WINDOW(256)) measure (
		.clock(clock),
		.resetn(resetn),
		.softClear(softClear_q),
		.pwmSync(pwmSync_q),
		.duty_q(duty)
	);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pwmMeta_q <= 1'b0;
			pwmSync_q <= 1'b0;
			limMeta_q <= 1'b0;
			limSync_q <= 1'b0;
		end else begin
			pwmMeta_q <= pwmIn;
			pwmSync_q <= pwmMeta_q;
			limMeta_q <= currentLimit;
			limSync_q <= limMeta_q;
		end
	end

	// Restart pulse lasts one cycle; the bit never reads back as one, since the read mux returns zero for 0x0F
	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			softClear_q <= 1'b0;
		else
			softClear_q <= wrRestart;
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			filter_q <= `FILTER_RESET;
			curA_q <= `CURRENT_RESET;
			curB_q <= `CURRENT_RESET;
			brA_q <= `BRIGHT_RESET;
			brB_q <= `BRIGHT_RESET;
			track_q <= 1'b0;
		end else if (softClear_q) begin
			filter_q <= `FILTER_RESET;
			curA_q <= `CURRENT_RESET;
			curB_q <= `CURRENT_RESET;
			brA_q <= `BRIGHT_RESET;
			brB_q <= `BRIGHT_RESET;
			track_q <= 1'b0;
		end else if (regWrite) begin
			case (regAddr)
				`ADDR_FILTER_LEVEL: filter_q <= regWdata[1:0];
				`ADDR_CURRENT_A: curA_q <= regWdata[4:0];
				`ADDR_CURRENT_B: curB_q <= regWdata[4:0];
				`ADDR_BRIGHT_A: brA_q <= regWdata;
				`ADDR_BRIGHT_B: brB_q <= regWdata;
				`ADDR_TRACK_CTRL: track_q <= regWdata[`TRACK_BIT];
				default: filter_q <= filter_q;
			endcase
		end
	end

	// Duty registers are read-only here; writes would only race the detector
	always @* begin
		case (regAddr)
			`ADDR_SOFT_RESTART: rdata_d = 8'h00;
			`ADDR_DUTY_LOW: rdata_d = duty[7:0];
			`ADDR_DUTY_HIGH: rdata_d = {7'h00, duty[8]};
			`ADDR_SILICON_STEP: rdata_d = SILICON_STEP;
			`ADDR_FILTER_LEVEL: rdata_d = {6'h00, filter_q};
			`ADDR_CURRENT_A: rdata_d = {3'h0, curA_q};
			`ADDR_CURRENT_B: rdata_d = {3'h0, curB_q};
			`ADDR_BRIGHT_A: rdata_d = brA_q;
			`ADDR_BRIGHT_B: rdata_d = brB_q;
			`ADDR_TRACK_CTRL: rdata_d = {7'h00, track_q};
			default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			regRdata <= 8'h00;
		else if (regRead)
			regRdata <= rdata_d;
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fullScaleA <= `CURRENT_RESET;
			fullScaleB <= `CURRENT_RESET;
			sinkLevelA <= `BRIGHT_RESET;
			sinkLevelB <= `BRIGHT_RESET;
			inputFilterLevel <= `FILTER_RESET;
		end else begin
			fullScaleA <= curA_q;
			fullScaleB <= curB_q;
			sinkLevelA <= brA_q;
			sinkLevelB <= track_q ? brA_q : brB_q;
			inputFilterLevel <= filter_q;
		end
	end

	// Switching period timer; a limit hit latches the switch off until period end
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			per_q <= 8'h00;
			limHold_q <= 1'b0;
			powerSwitch <= 1'b0;
		end else begin
			per_q <= periodEnd ? 8'h00 : per_q + 8'h01;
			if (periodEnd)
				limHold_q <= 1'b0;
			else if (limSync_q)
				limHold_q <= 1'b1;
			powerSwitch <= !periodEnd && !limHold_q && !limSync_q;
		end
	end
endmodule // backlight_misc_registers

// ---- test/backlight_misc_assertions.sv ----
`timescale 1ns/1ns
module backlight_misc_assertions #(parameter [7:0] SILICON_STEP = 8'h5A) (
	input wire clock,
	input wire resetn,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire [7:0] regRdata,
	input wire currentLimit,
	input wire powerSwitch,
	input wire [4:0] fullScaleA,
	input wire [7:0] sinkLevelA,
	input wire [1:0] inputFilterLevel
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_restart_clear: assert property (regWrite && regAddr==8'h0F && regWdata[0] |->
		##[2:3] fullScaleA==0 && sinkLevelA==0 && inputFilterLevel==0) else $error("clear");
	a_restart_zero: assert property (regRead && regAddr==8'h0F |=> regRdata==0)
		else $error("restart");
	a_duty_top: assert property (regRead && regAddr==8'h13 |=> regRdata[7:1]==0)
		else $error("duty");
	a_step_read: assert property (regRead && regAddr==8'h1F |=> regRdata==SILICON_STEP)
		else $error("step");
	a_filter_set: assert property (regWrite && regAddr==8'h50 |->
		##2 inputFilterLevel==$past(regWdata[1:0], 2)) else $error("filter");
	a_scale_set: assert property (regWrite && regAddr==8'h05 |->
		##2 fullScaleA==$past(regWdata[4:0], 2)) else $error("scale");
	a_level_set: assert property (regWrite && regAddr==8'h03 |->
		##2 sinkLevelA==$past(regWdata, 2)) else $error("level");
	// Sync delay sets the lower bound
	a_limit_off: assert property ($rose(currentLimit) |-> ##[2:4] !powerSwitch)
		else $error("switch");
	c_restart: cover property (regWrite && regAddr==8'h0F);
	c_limit: cover property ($rose(currentLimit));
	c_duty: cover property (regRead && regAddr==8'h13);
endmodule // backlight_misc_assertions

// ---- test/host.sv ----
`timescale 1ns/1ns
module host (
	input wire clock,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata
);
	logic [7:0] expQ[$];
	initial {regWrite, regRead, regAddr, regWdata} = 18'h0_0000;
	// One access, then one idle cycle; read value expected goes in d
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		{regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
		if (!w) expQ.push_back(d);
		@(negedge clock);
		{regWrite, regRead} = 2'b00;
		regWdata = ~d;
	endtask
endmodule // host

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
	logic clock = 0, resetn = 0, pwmIn = 0, currentLimit = 0;
	logic regWrite, regRead, powerSwitch;
	logic [7:0] regAddr, regWdata, regRdata, sinkLevelA, sinkLevelB, v;
	logic [4:0] fullScaleA, fullScaleB;
	logic [1:0] inputFilterLevel;
	logic [31:0] seed = 32'h4570_8eec;
	int fail_count = 0, checked = 0, n;
	initial forever #5 clock = ~clock;
	host host_inst (.*);
	backlight_misc_registers backlight_misc_registers_inst (.*);
	task check(input string nm, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	always @(posedge clock) if (regRead) begin
		@(negedge clock);
		check("rdata", regRdata, host_inst.expQ.pop_front());
	end
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock) resetn = 1;
		host_inst.acc(0, 8'h50, 8'h00);
		host_inst.acc(1, 8'h50, 8'h03);
		host_inst.acc(0, 8'h50, 8'h03);
		check("filter", {6'b0, inputFilterLevel}, 8'h03);
		host_inst.acc(0, 8'h1F, 8'h5A);
		host_inst.acc(0, 8'h77, 8'h00);
		v = rnd();
		host_inst.acc(1, 8'h05, v);
		host_inst.acc(1, 8'h06, ~v);
		host_inst.acc(1, 8'h03, v);
		host_inst.acc(1, 8'h04, ~v);
		repeat (3) @(negedge clock);
		check("scaleB", {3'b0, fullScaleB}, {3'b0, ~v[4:0]});
		check("levelB", sinkLevelB, ~v);
		check("scaleA", {3'b0, fullScaleA}, {3'b0, v[4:0]});
		check("levelA", sinkLevelA, v);
		host_inst.acc(1, 8'h00, 8'h01);
		repeat (3) @(negedge clock);
		check("levelB", sinkLevelB, v);
		pwmIn = 1;
		// Long enough for one whole window of high samples
		repeat (600) @(negedge clock);
		host_inst.acc(0, 8'h12, 8'h00);
		host_inst.acc(0, 8'h13, 8'h01);
		pwmIn = 0;
		host_inst.acc(1, 8'h0F, 8'h01);
		host_inst.acc(0, 8'h0F, 8'h00);
		host_inst.acc(0, 8'h13, 8'h00);
		check("levelB", sinkLevelB, 8'h00);
		check("filter", {6'b0, inputFilterLevel}, 8'h00);
		check("scaleA", {3'b0, fullScaleA}, 8'h00);
		n = 0;
		while (powerSwitch !== 0 && n < 200) begin
			@(negedge clock);
			n++;
		end
		currentLimit = 1;
		repeat (5) @(negedge clock);
		check("switch", {7'b0, powerSwitch}, 8'h00);
		summarize();
	end
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
endmodule // tb
bind backlight_misc_registers backlight_misc_assertions #(.SILICON_STEP(SILICON_STEP)) chk (.*);
